//--- dtfs_regs.svh
// constants for the dual tone frequency synthesizer
`ifndef DTFS_REGS_SVH
`define DTFS_REGS_SVH
// ==========================================================
// divider chain
`define DTFS_STEPS      5'h17
`define DTFS_LAST_STEP  5'h16
`define DTFS_MEL_HIGH   5'h0c
`define DTFS_PRE_EXTRA  9'h001
// ==========================================================
// amplitude, divisor limits and reset values
`define DTFS_LOW_GAIN   17'sh000cb
`define DTFS_MIN_MEL    8'h02
`define DTFS_MIN_TONE   8'h3c
`define DTFS_DIV_OFF    8'h00
`define DTFS_PRE_RST    9'h000
`define DTFS_STEP_RST   5'h00
`define DTFS_TONE_RST   9'sh000
`endif

//--- dtfs_pkg.sv
// types shared by the tone synthesizer modules
package dtfs_pkg;
  typedef logic        [7:0] dtfs_div_t;
  typedef logic signed [7:0] dtfs_smp_t;
  typedef logic signed [8:0] dtfs_tone_t;

  // one synthesizer's state
  typedef struct packed {
    dtfs_div_t  div;
    logic [8:0] pre;
    logic [4:0] step;
  } dtfs_synth_st_t;

  // what a synthesizer hands to the mixer
  typedef struct packed {
    dtfs_smp_t sample;
    logic      melody;
    logic      active;
  } dtfs_wave_t;

  // top level state
  typedef struct packed {
    dtfs_tone_t tone;
    logic       tone_en;
    logic       pin_out;
    logic       pin_oe;
    logic       pin_level;
  } dtfs_top_st_t;
endpackage : dtfs_pkg

//--- dtfs_synth.sv
// one digital sine synthesizer with its divide-by-23 step chain
`timescale 1ns/100ps
`include "dtfs_regs.svh"
module dtfs_synth (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic               gen_on,
  input  wire dtfs_pkg::dtfs_div_t divisor,
  output      dtfs_pkg::dtfs_wave_t wave
);
  import dtfs_pkg::*;

  dtfs_synth_st_t st;
  dtfs_synth_st_t next_st;
  logic           sub_end;
  logic           boundary;
  dtfs_smp_t      sample;
  logic           running;

  // ==========================================================
  // sine table, 23 points of one period
  function automatic dtfs_smp_t sine_at(input logic [4:0] k);
    unique case (k)
      5'h00: sine_at = 8'sh00;  5'h01: sine_at = 8'sh22;
      5'h02: sine_at = 8'sh42;  5'h03: sine_at = 8'sh5d;
      5'h04: sine_at = 8'sh71;  5'h05: sine_at = 8'sh7c;
      5'h06: sine_at = 8'sh7f;  5'h07: sine_at = 8'sh78;
      5'h08: sine_at = 8'sh68;  5'h09: sine_at = 8'sh50;
      5'h0a: sine_at = 8'sh33;  5'h0b: sine_at = 8'sh11;
      5'h0c: sine_at = -8'sh11; 5'h0d: sine_at = -8'sh33;
      5'h0e: sine_at = -8'sh50; 5'h0f: sine_at = -8'sh68;
      5'h10: sine_at = -8'sh78; 5'h11: sine_at = -8'sh7f;
      5'h12: sine_at = -8'sh7c; 5'h13: sine_at = -8'sh71;
      5'h14: sine_at = -8'sh5d; 5'h15: sine_at = -8'sh42;
      5'h16: sine_at = -8'sh22;
      default: sine_at = 8'sh00;  // steps above 22 never occur
    endcase
  endfunction : sine_at

  // ==========================================================
  // step chain: each sub-step lasts divisor+2 clocks
  assign sub_end  = st.pre == ({1'b0, st.div} + `DTFS_PRE_EXTRA);
  assign boundary = sub_end && st.step == `DTFS_LAST_STEP;

  always_comb begin
    next_st = st;
    if (!gen_on) begin
      next_st.div  = `DTFS_DIV_OFF;  // whole generator shut off
      next_st.pre  = `DTFS_PRE_RST;
      next_st.step = `DTFS_STEP_RST;
    end else if (st.div == `DTFS_DIV_OFF || boundary) begin
      // new divisor only at a period edge or from idle; only the gen_on shutoff cuts a period short
      next_st.div  = divisor;
      next_st.pre  = `DTFS_PRE_RST;
      next_st.step = `DTFS_STEP_RST;
    end else if (sub_end) begin
      next_st.pre  = `DTFS_PRE_RST;
      next_st.step = st.step + 5'h01;
    end else begin
      next_st.pre  = st.pre + 9'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{div: `DTFS_DIV_OFF, pre: `DTFS_PRE_RST, step: `DTFS_STEP_RST};
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs: a zero divisor silences both sine and square
  assign sample  = sine_at(st.step);
  assign running = st.div != `DTFS_DIV_OFF;
  // one assignment for the whole struct keeps a single driver on it
  assign wave = '{sample: running ? sample : 8'sh00,
                  melody: running && (st.step < `DTFS_MEL_HIGH),
                  active: running};

  // ==========================================================
  // checks
  sequence s_sub_end;
    ce && wave.active && sub_end;
  endsequence

  chk_step_hold: assert property (@(posedge clk)
    disable iff (!rst_n)
    (ce && gen_on && wave.active && !sub_end) |=> $stable(st.step))
    else $error("step moved before the sub-step ended");

  chk_step_advance: assert property (@(posedge clk)
    disable iff (!rst_n)
    (s_sub_end and (gen_on && st.step != `DTFS_LAST_STEP))
    |=> st.step == $past(st.step) + 5'h01 && st.pre == 9'h000)
    else $error("step did not advance at sub-step end");

  chk_div_latch: assert property (@(posedge clk)
    disable iff (!rst_n)
    (ce && gen_on && wave.active && !boundary) |=> $stable(st.div))
    else $error("divisor changed inside a period");

  chk_zero_silent: assert property (@(posedge clk)
    disable iff (!rst_n)
    !wave.active |-> (wave.sample == 8'sh00 && !wave.melody))
    else $error("stopped synthesizer still produces output");

  chk_duty_cycle: assert property (@(posedge clk)
    disable iff (!rst_n)
    wave.active |-> wave.melody == (st.step <= 5'h0b))
    else $error("melody duty not 12 of 23 steps");
endmodule : dtfs_synth

//--- dtfs_top.sv
// dual tone frequency synthesizer: two sines, summed tone and melody pin
`timescale 1ns/100ps
`include "dtfs_regs.svh"
module dtfs_top (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                ce,
  input  wire dtfs_pkg::dtfs_div_t high_group_divisor,
  input  wire dtfs_pkg::dtfs_div_t low_group_divisor,
  input  wire logic                melody_pin_select,
  input  wire logic                port_latch,
  input  wire logic                melody_port_pin_in,
  output      logic                melody_port_pin_out,
  output      logic                melody_port_pin_oe,
  output      logic                melody_pin_level,
  output      dtfs_pkg::dtfs_tone_t tone_level,
  output      logic                tone_drive_en
);
  import dtfs_pkg::*;

  logic [1:0]        rst_sync;
  logic              rst_n;
  logic              gen_on;
  dtfs_wave_t        high_wave;
  dtfs_wave_t        low_wave;
  logic signed [16:0] mix;
  dtfs_top_st_t      st;
  dtfs_top_st_t      next_st;
  logic              mel_prev;     // melody seen at the last enabled edge
  logic [12:0]       mel_len;      // enabled cycles of the current part
  logic [12:0]       mel_hi_len;   // length of the last high part
  logic              mel_seen_hi;  // a whole high part has been counted

  // ==========================================================
  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================================
  // two independent synthesizers; holding both off saves power
  assign gen_on = high_group_divisor != `DTFS_DIV_OFF ||
                  low_group_divisor != `DTFS_DIV_OFF;

  dtfs_synth u_high (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .gen_on  (gen_on),
    .divisor (high_group_divisor),
    .wave    (high_wave)
  );

  dtfs_synth u_low (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .gen_on  (gen_on),
    .divisor (low_group_divisor),
    .wave    (low_wave)
  );

  // ==========================================================
  // mixer: low group weighted by 203/256, about -2 dB
  assign mix = (17'(high_wave.sample) <<< 8) +
               17'(low_wave.sample) * `DTFS_LOW_GAIN;

  // ==========================================================
  // output state; the tone keeps running while the melody pin is used,
  // though divisors below 60 are lost in the outside filter
  always_comb begin
    next_st           = st;
    next_st.tone      = 9'(mix >>> 8);
    next_st.tone_en   = high_wave.active || low_wave.active;
    next_st.pin_level = melody_port_pin_in;
    if (melody_pin_select) begin
      // zero divisor leaves the pin high; any divisor from 2 up toggles
      next_st.pin_out = (high_group_divisor == `DTFS_DIV_OFF) ? 1'b1
                        : high_wave.melody;
      next_st.pin_oe  = 1'b1;
    end else begin
      // plain port line: strong low, weak pull-up for high
      next_st.pin_out = port_latch;
      next_st.pin_oe  = !port_latch;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{tone: `DTFS_TONE_RST, tone_en: 1'b0, pin_out: 1'b1,
              pin_oe: 1'b0, pin_level: 1'b1};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign tone_level          = st.tone;
  assign tone_drive_en       = st.tone_en;
  assign melody_port_pin_out = st.pin_out;
  assign melody_port_pin_oe  = st.pin_oe;
  assign melody_pin_level    = st.pin_level;

  // ==========================================================
  // check helpers: lengths of the high and low parts of a melody
  // period in enabled cycles; a stopped synthesizer drops the
  // half-seen period, so a cut period is never judged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mel_prev    <= 1'b0;
      mel_len     <= 13'h0000;
      mel_hi_len  <= 13'h0000;
      mel_seen_hi <= 1'b0;
    end else if (ce) begin
      mel_prev <= high_wave.melody;
      if (!high_wave.active) begin
        mel_seen_hi <= 1'b0;
      end else if (high_wave.melody != mel_prev) begin
        mel_len <= 13'h0001;
        if (!high_wave.melody) begin
          mel_hi_len  <= mel_len;  // a high part just ended
          mel_seen_hi <= 1'b1;
        end
      end else begin
        mel_len <= mel_len + 13'h0001;
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_gen_off;
    ce && !gen_on;
  endsequence

  sequence s_high_wake;
    ce && high_group_divisor != `DTFS_DIV_OFF && !high_wave.active;
  endsequence

  chk_gen_shutoff: assert property (@(posedge clk)
    disable iff (!rst_n)
    s_gen_off ##1 s_gen_off |=> !tone_drive_en)
    else $error("tone driven while both divisors are zero");

  chk_tone_float: assert property (@(posedge clk)
    disable iff (!rst_n)
    (ce && !high_wave.active && !low_wave.active) |=> !tone_drive_en)
    else $error("tone output driven with no tone");

  chk_melody_idle: assert property (@(posedge clk)
    disable iff (!rst_n)
    (ce && melody_pin_select && high_group_divisor == 8'h00)
    |=> melody_port_pin_out && melody_port_pin_oe)
    else $error("melody pin not high with zero divisor");

  chk_melody_route: assert property (@(posedge clk)
    disable iff (!rst_n)
    (ce && melody_pin_select && high_group_divisor != 8'h00)
    |=> melody_port_pin_out == $past(high_wave.melody))
    else $error("melody not routed to the pin");

  chk_tone_sum: assert property (@(posedge clk)
    disable iff (!rst_n)
    (ce && !low_wave.active && high_wave.active)
    |=> tone_level == 9'($past(high_wave.sample)))
    else $error("tone not following the high group sine");

  // a divisor from idle must bring the tone driver up two edges later
  chk_tone_wake: assert property (@(posedge clk)
    disable iff (!rst_n)
    s_high_wake ##1 ce |=> tone_drive_en)
    else $error("tone not started by a nonzero divisor");

  chk_tone_beside: assert property (@(posedge clk)
    disable iff (!rst_n)
    (ce && melody_pin_select && high_wave.active) |=> tone_drive_en)
    else $error("sine stopped while the melody runs");

  chk_low_gain: assert property (@(posedge clk)
    disable iff (!rst_n)
    (ce && low_wave.active && !high_wave.active)
    |=> 17'(tone_level)
        == ((17'($past(low_wave.sample)) * `DTFS_LOW_GAIN) >>> 8))
    else $error("low group sine not scaled down");

  chk_port_line: assert property (@(posedge clk)
    disable iff (!rst_n)
    (ce && !melody_pin_select)
    |=> melody_port_pin_out == $past(port_latch)
        && melody_port_pin_oe == !$past(port_latch))
    else $error("plain port line not following the latch");

  chk_level_copy: assert property (@(posedge clk)
    disable iff (!rst_n)
    ce |=> melody_pin_level == $past(melody_port_pin_in))
    else $error("pin level not copied from the wire");

  // high part times 11 must equal low part times 12 in every period
  chk_melody_duty: assert property (@(posedge clk)
    disable iff (!rst_n)
    (ce && mel_seen_hi && high_wave.active && high_wave.melody && !mel_prev)
    |-> int'(mel_hi_len) * (`DTFS_STEPS - `DTFS_MEL_HIGH)
        == int'(mel_len) * `DTFS_MEL_HIGH)
    else $error("melody high part not 12 of 23");
endmodule : dtfs_top

//--- dtfs_line_model.sv
// far side model: ringer pin wire and telephone tone line
`timescale 1ns/100ps
module dtfs_line_model (
  input  wire logic                 clk,
  input  wire logic                 pin_out,
  input  wire logic                 pin_oe,
  input  wire dtfs_pkg::dtfs_tone_t tone_level,
  input  wire logic                 tone_drive_en,
  output      logic                 pin_wire,
  output      dtfs_pkg::dtfs_tone_t tone_line
);
  import dtfs_pkg::*;
  dtfs_tone_t last_tone;
  // ==========================================================
  // pin has a pull-up, so a released pin reads high
  assign pin_wire = pin_oe ? pin_out : 1'b1;
  // a floating tone line never shows the last sample again
  assign tone_line = tone_drive_en ? tone_level : ~last_tone;
  always @(posedge clk) begin
    if (tone_drive_en) last_tone <= tone_level;
  end
endmodule : dtfs_line_model

//--- tb_dtfs_top.sv
// self-checking bench for the dual tone synthesizer
`timescale 1ns/100ps
module tb_dtfs_top;
  import dtfs_pkg::*;
  logic       clk, resetn, ce, sel, latch;
  logic       pin_wire, pin_out, pin_oe, pin_lvl, tone_en;
  dtfs_div_t  hg, lg, x, y;
  dtfs_tone_t tone, line, mx;
  logic [31:0] lfsr;
  int         num_errors, n_checks, n, i;
  // ==========================================================
  // design and far side
  dtfs_top dtfs_top_inst (.clk(clk), .resetn(resetn), .ce(ce),
    .high_group_divisor(hg), .low_group_divisor(lg),
    .melody_pin_select(sel), .port_latch(latch),
    .melody_port_pin_in(pin_wire), .melody_port_pin_out(pin_out),
    .melody_port_pin_oe(pin_oe), .melody_pin_level(pin_lvl),
    .tone_level(tone), .tone_drive_en(tone_en));
  dtfs_line_model dtfs_line_model_inst (.clk(clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .tone_level(tone), .tone_drive_en(tone_en),
    .pin_wire(pin_wire), .tone_line(line));
  always #5 clk = ~clk;
  // ==========================================================
  // expectations and helpers
  function automatic int exp_hi(input dtfs_div_t d);
    return 12 * (int'(d) + 2);
  endfunction : exp_hi
  function automatic int exp_lo(input dtfs_div_t d);
    return 11 * (int'(d) + 2);
  endfunction : exp_lo
  // a lone low sine reads zero only in step 0 of its 23 steps
  function automatic int exp_nz(input dtfs_div_t d);
    return 22 * (int'(d) + 2);
  endfunction : exp_nz
  function automatic dtfs_div_t row_code(input logic [1:0] k);
    case (k)
      2'h0: return 8'hdd;
      2'h1: return 8'hc8;
      2'h2: return 8'hb5;
      default: return 8'ha3;
    endcase
  endfunction : row_code
  function automatic dtfs_div_t col_code(input logic [1:0] k);
    case (k)
      2'h0: return 8'h7f;
      2'h1: return 8'h72;
      2'h2: return 8'h67;
      default: return 8'h5d;
    endcase
  endfunction : col_code
  function automatic dtfs_tone_t exp_peak(input int h, input int l);
    return dtfs_tone_t'((h * 127 * 256 + l * 127 * 203) >>> 8);
  endfunction : exp_peak
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
    end
  endtask : tick
  // counts cycles while the pin wire holds lvl; bounded against hangs
  task automatic run_len(input logic lvl, output int c);
    c = 0;
    while (pin_wire === lvl && c < 20000) begin
      tick(1);
      c++;
    end
  endtask : run_len
  // waits for the tone to leave zero, then counts until it returns
  task automatic run_tone(output int c);
    c = 0;
    while (tone === 9'sh000 && c < 20000) begin
      tick(1);
      c++;
    end
    c = 0;
    while (tone !== 9'sh000 && c < 20000) begin
      tick(1);
      c++;
    end
  endtask : run_tone
  task automatic peak(input int k);
    mx = 9'sh100;
    repeat (k) begin
      tick(1);
      if (tone_en === 1'b1 && tone > mx) mx = tone;
    end
  endtask : peak
  task automatic give_verdict;
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // watchdog: the whole run needs well under 100k cycles
  initial begin
    #1000000;
    num_errors++;
    give_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    clk = 0; resetn = 0; ce = 1; sel = 0; latch = 1;
    hg = 8'h00; lg = 8'h00; lfsr = 32'h000173ed;
    num_errors = 0; n_checks = 0;
    tick(4);
    check(tone_en === 1'b0 && pin_out === 1'b1, "reset levels");
    tick(1);
    resetn = 1;
    tick(3);
    // melody with a divisor change inside each period, first x is 2
    latch = 1;
    sel = 1;
    x = 8'h02;
    hg = x;
    run_len(1'b1, n);
    run_len(1'b0, n);
    for (i = 0; i < 4; i++) begin
      run_len(1'b1, n);
      check(n == exp_hi(x), "melody high time");
      check(tone_en === 1'b1, "sine runs beside melody");
      lfsr = lfsr_next(lfsr);
      y = 8'h02 + dtfs_div_t'(lfsr[2:0]);
      hg = y;
      run_len(1'b0, n);
      check(n == exp_lo(x), "period kept over change");
      x = y;
    end
    // idle pin and full shutoff
    hg = 8'h00;
    tick(3);
    check(pin_out === 1'b1 && pin_oe === 1'b1, "idle melody high");
    check(tone_en === 1'b0 && line !== tone, "generator off");
    // plain port mode for both latch values
    sel = 0;
    for (i = 0; i < 2; i++) begin
      latch = i[0];
      tick(3);
      check(pin_out === latch && pin_oe === !latch, "port mode");
      check(pin_lvl === pin_wire, "pin level copy");
    end
    latch = 1;
    // single tone, then low group alone
    hg = 8'h9d;
    peak(23 * (8'h9d + 2) + 4);
    check(mx === exp_peak(1, 0), "high sine peak");
    hg = 8'h00;
    tick(3);
    lg = 8'hdd;
    peak(23 * (8'hdd + 2) + 4);
    check(mx === exp_peak(0, 1), "low sine scaled");
    lg = 8'h00;
    tick(3);
    // both started together from idle so their phases line up
    lfsr = lfsr_next(lfsr);
    x = 8'h02 + dtfs_div_t'(lfsr[3:0]);
    hg = x;
    lg = x;
    peak(23 * (int'(x) + 2) + 4);
    check(mx === exp_peak(1, 1), "summed peak");
    // a random key: column on the pin, then its row alone on the tone;
    // ce drops inside the high part and must freeze the period
    hg = 8'h00;
    lg = 8'h00;
    tick(3);
    lfsr = lfsr_next(lfsr);
    x = col_code(lfsr[1:0]);
    y = row_code(lfsr[3:2]);
    sel = 1;
    hg = x;
    lg = y;
    run_len(1'b1, n);
    run_len(1'b0, n);
    ce = 0;
    tick(5);
    ce = 1;
    run_len(1'b1, n);
    check(n == exp_hi(x), "column period with ce frozen");
    hg = 8'h00;
    lg = 8'h00;
    tick(3);
    lg = y;
    run_tone(n);
    check(n == exp_nz(y), "row tone period");
    give_verdict();
  end
endmodule : tb_dtfs_top
